/* File: hdl/chan_status_led_ctrl.sv */
/*
  channel b status/control register, indicator pin control register, fault latching,
  soft reset sequencing and indicator pin muxing, behind the serial register port.
  assumes an spi mode 0 master with sclk at most one tenth of clock_i, fault inputs from
  the analog supply and driver monitors, receive flags from logic on clock_i.
*/
`default_nettype none

module chan_status_led_ctrl (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_en_n_o,
  input wire chan_status_pkg::fault_t chan_b_fault_i,
  input wire chan_status_pkg::rx_status_t rx_status_i,
  output chan_status_pkg::indicator_pins_t indicator_pins_o,
  output logic chan_b_internal_framer_on_o,
  output logic chan_b_soft_reset_o,
  output logic shared_status_irq_o
);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  chan_status_pkg::spi_pins_t spi_raw;
  chan_status_pkg::spi_pins_t spi_f;
  chan_status_pkg::fault_t fault_now;

  assign spi_raw = '{sclk: spi_sclk_i, cs_n: spi_cs_n_i, mosi: spi_mosi_i};

  sync_filter #(
    .WIDTH(3),
    .RESET_VALUE(chan_status_pkg::SPI_IDLE)
  ) u_spi_sync (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .async_i(spi_raw),
    .level_o(spi_f)
  );

  // the analog monitors are slow; filtering also hides single-cycle glitches
  sync_filter #(
    .WIDTH(3),
    .RESET_VALUE(chan_status_pkg::FAULT_CLEAR)
  ) u_fault_sync (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .async_i(chan_b_fault_i),
    .level_o(fault_now)
  );

  // ****************************************************************
  // register state declarations
  // ****************************************************************
  chan_status_pkg::soft_reset_state_t sr_state;
  chan_status_pkg::soft_reset_state_t next_sr_state;
  logic framer_on;
  logic next_framer_on;
  logic [7:0] indicator_ctrl;
  logic [7:0] next_indicator_ctrl;
  chan_status_pkg::fault_t latched;
  chan_status_pkg::fault_t next_latched;
  chan_status_pkg::fault_t fault_prev;
  chan_status_pkg::fault_t fault_rise;
  logic [7:0] status_read_value;

  // ****************************************************************
  // serial frame engine
  // ****************************************************************
  logic sclk_prev;
  logic [4:0] bit_cnt;
  logic [7:0] rx_shift;
  logic [7:0] cmd;
  logic [7:0] tx_shift;
  logic miso_en_n;
  logic [4:0] next_bit_cnt;
  logic [7:0] next_rx_shift;
  logic [7:0] next_cmd;
  logic [7:0] next_tx_shift;
  logic sclk_rise;
  logic sclk_fall;
  logic read_req;
  logic write_req;
  logic [6:0] read_addr;
  logic [7:0] write_data;
  logic [7:0] read_value;

  assign sclk_rise = spi_f.sclk & ~sclk_prev;
  assign sclk_fall = ~spi_f.sclk & sclk_prev;

  always_comb begin
    next_bit_cnt = bit_cnt;
    next_rx_shift = rx_shift;
    next_cmd = cmd;
    next_tx_shift = tx_shift;
    read_req = 1'b0;
    write_req = 1'b0;
    read_addr = cmd[6:0];
    write_data = rx_shift;
    if (spi_f.cs_n) begin
      next_bit_cnt = chan_status_pkg::SPI_COUNT_ZERO;
      next_tx_shift = chan_status_pkg::READ_UNMAPPED;
    end else if (sclk_rise && (bit_cnt != chan_status_pkg::SPI_FRAME_DONE)) begin
      // clocks past the sixteenth are ignored until chip select rises
      next_rx_shift = {rx_shift[6:0], spi_f.mosi};
      next_bit_cnt = bit_cnt + chan_status_pkg::SPI_COUNT_ONE;
      if (next_bit_cnt == chan_status_pkg::SPI_CMD_DONE) begin
        next_cmd = next_rx_shift;
        if (next_rx_shift[chan_status_pkg::CMD_READ_BIT]) begin
          read_req = 1'b1;
          read_addr = next_rx_shift[6:0];
          next_tx_shift = read_value;
        end
      end else if (next_bit_cnt == chan_status_pkg::SPI_FRAME_DONE) begin
        write_req = ~cmd[chan_status_pkg::CMD_READ_BIT];
        write_data = next_rx_shift;
      end
    end else if (sclk_fall && (bit_cnt >= chan_status_pkg::SPI_SHIFT_FROM)) begin
      next_tx_shift = {tx_shift[6:0], 1'b0};
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      sclk_prev <= 1'b0;
      bit_cnt <= chan_status_pkg::SPI_COUNT_ZERO;
      rx_shift <= chan_status_pkg::READ_UNMAPPED;
      cmd <= chan_status_pkg::READ_UNMAPPED;
      tx_shift <= chan_status_pkg::READ_UNMAPPED;
      miso_en_n <= 1'b1;
    end else begin
      sclk_prev <= spi_f.sclk;
      bit_cnt <= next_bit_cnt;
      rx_shift <= next_rx_shift;
      cmd <= next_cmd;
      tx_shift <= next_tx_shift;
      miso_en_n <= spi_f.cs_n;
    end
  end

  assign spi_miso_o = tx_shift[7];
  assign spi_miso_en_n_o = miso_en_n;

  // ****************************************************************
  // read mux
  // ****************************************************************
  always_comb begin
    status_read_value = chan_status_pkg::CHAN_B_STATUS_RESET;
    status_read_value[chan_status_pkg::BIT_SOFT_RESET] = (sr_state == chan_status_pkg::SR_FLUSH);
    status_read_value[chan_status_pkg::BIT_FRAMER_ON] = framer_on;
    status_read_value[chan_status_pkg::BIT_CURLIM_LATCHED] = latched.curlim;
    status_read_value[chan_status_pkg::BIT_UNDERVOLT_LATCHED] = latched.undervolt;
    status_read_value[chan_status_pkg::BIT_LINE_FAULT_LATCHED] = latched.line_fault;
    status_read_value[chan_status_pkg::BIT_CURLIM_NOW] = fault_now.curlim;
    status_read_value[chan_status_pkg::BIT_UNDERVOLT_NOW] = fault_now.undervolt;
    status_read_value[chan_status_pkg::BIT_LINE_FAULT_NOW] = fault_now.line_fault;
  end

  always_comb begin
    if (read_addr == chan_status_pkg::ADDR_CHAN_B_STATUS_CONTROL) begin
      read_value = status_read_value;
    end else if (read_addr == chan_status_pkg::ADDR_INDICATOR_PIN_CONTROL) begin
      read_value = indicator_ctrl;
    end else begin
      read_value = chan_status_pkg::READ_UNMAPPED;
    end
  end

  // ****************************************************************
  // control and status registers
  // ****************************************************************
  logic status_write;
  logic indicator_write;
  logic status_read;

  assign status_write = write_req && (cmd[6:0] == chan_status_pkg::ADDR_CHAN_B_STATUS_CONTROL);
  assign indicator_write = write_req && (cmd[6:0] == chan_status_pkg::ADDR_INDICATOR_PIN_CONTROL);
  assign status_read = read_req && (read_addr == chan_status_pkg::ADDR_CHAN_B_STATUS_CONTROL);
  assign fault_rise = fault_now & ~fault_prev;

  always_comb begin
    next_sr_state = sr_state;
    next_framer_on = framer_on;
    next_indicator_ctrl = indicator_ctrl;
    next_latched = latched;
    // the value shifted out was sampled before this clear, so no event goes unseen
    if (status_read) begin
      next_latched = chan_status_pkg::FAULT_CLEAR;
    end
    case (sr_state)
      chan_status_pkg::SR_IDLE: begin
        if (status_write) begin
          next_framer_on = write_data[chan_status_pkg::BIT_FRAMER_ON];
          if (write_data[chan_status_pkg::BIT_SOFT_RESET]) begin
            next_sr_state = chan_status_pkg::SR_FLUSH;
          end
        end
      end
      chan_status_pkg::SR_FLUSH: begin
        // only channel b bits return to reset; indicator control is shared and kept
        next_framer_on =
          chan_status_pkg::CHAN_B_STATUS_RESET[chan_status_pkg::BIT_FRAMER_ON];
        next_latched = chan_status_pkg::FAULT_CLEAR;
        next_sr_state = chan_status_pkg::SR_IDLE;
      end
      default: begin
        next_sr_state = chan_status_pkg::SR_IDLE;
      end
    endcase
    if (indicator_write) begin
      next_indicator_ctrl = write_data;
    end
    // set wins over any clear in the same cycle
    next_latched = next_latched | fault_rise;
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      sr_state <= chan_status_pkg::SR_IDLE;
      framer_on <= chan_status_pkg::CHAN_B_STATUS_RESET[chan_status_pkg::BIT_FRAMER_ON];
      indicator_ctrl <= chan_status_pkg::INDICATOR_PIN_RESET;
      latched <= chan_status_pkg::FAULT_CLEAR;
      fault_prev <= chan_status_pkg::FAULT_CLEAR;
    end else begin
      sr_state <= next_sr_state;
      framer_on <= next_framer_on;
      indicator_ctrl <= next_indicator_ctrl;
      latched <= next_latched;
      fault_prev <= fault_now;
    end
  end

  assign chan_b_soft_reset_o = (sr_state == chan_status_pkg::SR_FLUSH);
  assign chan_b_internal_framer_on_o = framer_on;
  assign shared_status_irq_o = |latched;

  // ****************************************************************
  // indicator pins
  // ****************************************************************
  chan_status_pkg::indicator_pins_t pins;
  chan_status_pkg::indicator_pins_t next_pins;

  // interrupt masks never enter here, so status mode shows the raw flags
  always_comb begin
    next_pins.chan_b_error_indicator_pin = indicator_ctrl[chan_status_pkg::BIT_B_ERR_PIN_MODE] ?
      rx_status_i.chan_b_receive_error_flag :
      indicator_ctrl[chan_status_pkg::BIT_B_LED2_ON];
    next_pins.chan_b_ready_indicator_pin = indicator_ctrl[chan_status_pkg::BIT_B_READY_PIN_MODE] ?
      rx_status_i.chan_b_receive_ready_flag :
      indicator_ctrl[chan_status_pkg::BIT_B_LED1_ON];
    next_pins.chan_a_error_indicator_pin = indicator_ctrl[chan_status_pkg::BIT_A_ERR_PIN_MODE] ?
      rx_status_i.chan_a_receive_error_flag :
      indicator_ctrl[chan_status_pkg::BIT_A_LED2_ON];
    next_pins.chan_a_ready_indicator_pin = indicator_ctrl[chan_status_pkg::BIT_A_READY_PIN_MODE] ?
      rx_status_i.chan_a_receive_ready_flag :
      indicator_ctrl[chan_status_pkg::BIT_A_LED1_ON];
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      pins <= '0;
    end else begin
      pins <= next_pins;
    end
  end

  assign indicator_pins_o = pins;

endmodule : chan_status_led_ctrl

`default_nettype wire

/* File: hdl/sync_filter.sv */
/*
  three-stage synchroniser with agreement filter for asynchronous levels.
  assumes inputs change slower than a few clock periods; reset value is a constant.
*/
`default_nettype none

module sync_filter #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] level_o
);

  // ****************************************************************
  // stages
  // ****************************************************************
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] level;
  logic [WIDTH-1:0] next_level;

  // a bit moves only when stages two and three agree; stage one feeds stage two alone
  always_comb begin
    next_level = level;
    for (int i = 0; i < int'(WIDTH); i++) begin
      if (stage2[i] == stage3[i]) begin
        next_level[i] = stage2[i];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      stage1 <= RESET_VALUE;
      stage2 <= RESET_VALUE;
      stage3 <= RESET_VALUE;
      level <= RESET_VALUE;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
      level <= next_level;
    end
  end

  assign level_o = level;

endmodule : sync_filter

`default_nettype wire

/* File: pkg/chan_status_pkg.sv */
/*
  constants, field positions and carrier types for the channel b status / indicator pin block.
  assumes one 125 mhz clock and a synchronous active-low reset in every user.
*/
`default_nettype none

package chan_status_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [6:0] ADDR_CHAN_B_STATUS_CONTROL = 7'h0d;
  localparam logic [6:0] ADDR_INDICATOR_PIN_CONTROL = 7'h0e;
  localparam logic [7:0] CHAN_B_STATUS_RESET = 8'h00;
  localparam logic [7:0] INDICATOR_PIN_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned BIT_SOFT_RESET = 7;
  localparam int unsigned BIT_FRAMER_ON = 6;
  localparam int unsigned BIT_CURLIM_LATCHED = 5;
  localparam int unsigned BIT_UNDERVOLT_LATCHED = 4;
  localparam int unsigned BIT_LINE_FAULT_LATCHED = 3;
  localparam int unsigned BIT_CURLIM_NOW = 2;
  localparam int unsigned BIT_UNDERVOLT_NOW = 1;
  localparam int unsigned BIT_LINE_FAULT_NOW = 0;
  localparam int unsigned BIT_B_LED2_ON = 7;
  localparam int unsigned BIT_B_ERR_PIN_MODE = 6;
  localparam int unsigned BIT_B_LED1_ON = 5;
  localparam int unsigned BIT_B_READY_PIN_MODE = 4;
  localparam int unsigned BIT_A_LED2_ON = 3;
  localparam int unsigned BIT_A_ERR_PIN_MODE = 2;
  localparam int unsigned BIT_A_LED1_ON = 1;
  localparam int unsigned BIT_A_READY_PIN_MODE = 0;

  // ****************************************************************
  // serial register port framing
  // ****************************************************************
  localparam int unsigned CMD_READ_BIT = 7;
  localparam logic [4:0] SPI_COUNT_ZERO = 5'h00;
  localparam logic [4:0] SPI_COUNT_ONE = 5'h01;
  localparam logic [4:0] SPI_CMD_DONE = 5'h08;
  localparam logic [4:0] SPI_SHIFT_FROM = 5'h09;
  localparam logic [4:0] SPI_FRAME_DONE = 5'h10;

  // ****************************************************************
  // carrier types
  // ****************************************************************
  typedef struct packed {
    logic curlim;
    logic undervolt;
    logic line_fault;
  } fault_t;

  typedef struct packed {
    logic chan_b_receive_error_flag;
    logic chan_b_receive_ready_flag;
    logic chan_a_receive_error_flag;
    logic chan_a_receive_ready_flag;
  } rx_status_t;

  typedef struct packed {
    logic chan_b_error_indicator_pin;
    logic chan_b_ready_indicator_pin;
    logic chan_a_error_indicator_pin;
    logic chan_a_ready_indicator_pin;
  } indicator_pins_t;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
  } spi_pins_t;

  localparam spi_pins_t SPI_IDLE = '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
  localparam fault_t FAULT_CLEAR = '{curlim: 1'b0, undervolt: 1'b0, line_fault: 1'b0};

  typedef enum logic [1:0] {
    SR_IDLE = 2'b01,
    SR_FLUSH = 2'b10
  } soft_reset_state_t;

endpackage : chan_status_pkg

`default_nettype wire

/* File: sim/chan_status_led_ctrl_checker.sv */
/*
  port-level checker for the channel b status and indicator pin block.
  assumes one clock, a synchronous active-low reset, and the bind at the foot of this file.
*/
`default_nettype none

module chan_status_led_ctrl_checker (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic spi_cs_n_i,
  input wire chan_status_pkg::fault_t chan_b_fault_i,
  input wire chan_status_pkg::rx_status_t rx_status_i,
  input wire chan_status_pkg::indicator_pins_t indicator_pins_o,
  input wire logic chan_b_internal_framer_on_o,
  input wire logic chan_b_soft_reset_o,
  input wire logic shared_status_irq_o
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  // saturating counts: register changes need a frame, flag rises need a fault
  logic [3:0] cs_idle;
  logic [3:0] fault_age;
  always_ff @(posedge clock_i) begin
    if (!reset_n_i || !spi_cs_n_i) cs_idle <= 4'h0;
    else if (cs_idle != 4'hf) cs_idle <= cs_idle + 4'h1;
    if (!reset_n_i) fault_age <= 4'hf;
    else if (chan_b_fault_i != 3'h0) fault_age <= 4'h0;
    else if (fault_age != 4'hf) fault_age <= fault_age + 4'h1;
  end

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);

  // ****************************************************************
  // properties
  // ****************************************************************
  property p_soft_pulse;
    chan_b_soft_reset_o |=> !chan_b_soft_reset_o;
  endproperty
  property p_soft_framer;
    chan_b_soft_reset_o |=> !chan_b_internal_framer_on_o;
  endproperty
  property p_soft_by_write;
    chan_b_soft_reset_o |-> cs_idle != 4'hf;
  endproperty
  property p_irq_cause;
    $rose(shared_status_irq_o) |-> fault_age < 4'hc;
  endproperty
  property p_irq_clear;
    $fell(shared_status_irq_o) |-> cs_idle != 4'hf || $past(chan_b_soft_reset_o);
  endproperty
  property p_reset_state;
    $rose(reset_n_i) |-> indicator_pins_o == 4'h0 && !shared_status_irq_o
      && !chan_b_internal_framer_on_o;
  endproperty
  property p_pins_cause;
    cs_idle == 4'hf && $changed(indicator_pins_o) |-> $past(rx_status_i) != $past(rx_status_i, 2);
  endproperty
  property p_framer_cause;
    cs_idle == 4'hf && $changed(chan_b_internal_framer_on_o) |-> $past(chan_b_soft_reset_o);
  endproperty

  a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset pulse too long");
  a_soft_framer: assert property (p_soft_framer) else $error("framer on after soft reset");
  a_soft_by_write: assert property (p_soft_by_write) else $error("soft reset without frame");
  a_irq_cause: assert property (p_irq_cause) else $error("irq rose without fault");
  a_irq_clear: assert property (p_irq_clear) else $error("irq fell without read");
  a_reset_state: assert property (p_reset_state) else $error("outputs not cleared by reset");
  a_pins_cause: assert property (p_pins_cause) else $error("pins moved without cause");
  a_framer_cause: assert property (p_framer_cause) else $error("framer moved idle");

  c_soft: cover property (chan_b_soft_reset_o);
  c_irq: cover property ($rose(shared_status_irq_o));
  c_pins: cover property (cs_idle == 4'hf && $changed(indicator_pins_o));
endmodule : chan_status_led_ctrl_checker

bind chan_status_led_ctrl chan_status_led_ctrl_checker u_checker (.clock_i, .reset_n_i,
  .spi_cs_n_i, .chan_b_fault_i, .rx_status_i, .indicator_pins_o,
  .chan_b_internal_framer_on_o, .chan_b_soft_reset_o, .shared_status_irq_o);

`default_nettype wire

/* File: sim/chan_status_led_ctrl_tb.sv */
/*
  self-checking bench: serial register frames bit by bit, random led settings and flags,
  fault events, soft reset. assumes the checker binds itself to the design.
*/
`default_nettype none

module chan_status_led_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic spi_sclk_i = 1'b0;
  logic spi_cs_n_i = 1'b1;
  logic spi_mosi_i = 1'b0;
  logic spi_miso_o;
  logic spi_miso_en_n_o;
  chan_status_pkg::fault_t chan_b_fault_i = chan_status_pkg::FAULT_CLEAR;
  chan_status_pkg::rx_status_t rx_status_i = '0;
  chan_status_pkg::indicator_pins_t indicator_pins_o;
  logic chan_b_internal_framer_on_o;
  logic chan_b_soft_reset_o;
  logic shared_status_irq_o;
  int num_errors = 0;
  int samples_checked = 0;
  int soft_seen = 0;
  logic [31:0] lfsr_state = 32'h4ca2fad0;
  logic [7:0] led;
  logic [7:0] rx8;

  always #4 clock_i = ~clock_i;
  always @(posedge clock_i) if (chan_b_soft_reset_o === 1'b1) soft_seen++;

  chan_status_led_ctrl uut (.clock_i, .reset_n_i, .spi_sclk_i, .spi_cs_n_i, .spi_mosi_i,
    .spi_miso_o, .spi_miso_en_n_o, .chan_b_fault_i, .rx_status_i, .indicator_pins_o,
    .chan_b_internal_framer_on_o, .chan_b_soft_reset_o, .shared_status_irq_o);

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic cycles(input int n);
    repeat (n) @(posedge clock_i);
  endtask : cycles

  task automatic check(input logic [7:0] seen_v, input logic [7:0] exp_v);
    samples_checked++;
    if (seen_v !== exp_v) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask : check

  function automatic logic [7:0] rnd();
    for (int i = 0; i < 8; i++) begin
      lfsr_state = {lfsr_state[30:0],
        lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
    end
    return lfsr_state[7:0];
  endfunction : rnd

  function automatic logic [7:0] pins_exp(input logic [7:0] c, input logic [3:0] rx);
    return {4'h0, c[6] ? rx[3] : c[7], c[4] ? rx[2] : c[5],
      c[2] ? rx[1] : c[3], c[0] ? rx[0] : c[1]};
  endfunction : pins_exp

  // half periods of 8 clocks keep every pin well past the input filters
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] data, output logic [7:0] rd_v);
    logic [15:0] word;
    word = {cmd, data};
    rd_v = 8'h00;
    spi_cs_n_i <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi_i <= word[i];
      cycles(8);
      if (i < 8) rd_v[i] = spi_miso_o;
      spi_sclk_i <= 1'b1;
      cycles(8);
      spi_sclk_i <= 1'b0;
    end
    cycles(8);
    spi_cs_n_i <= 1'b1;
    cycles(16);
  endtask : xfer

  task automatic wr(input logic [6:0] addr, input logic [7:0] v);
    logic [7:0] unused;
    xfer({1'b0, addr}, v, unused);
  endtask : wr

  task automatic expect_reg(input logic [6:0] addr, input logic [7:0] exp_v);
    logic [7:0] got;
    xfer({1'b1, addr}, 8'h00, got);
    check(got, exp_v);
  endtask : expect_reg

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    cycles(10);
    reset_n_i <= 1'b1;
    cycles(6);
    expect_reg(7'h0e, 8'h00);
    expect_reg(7'h0d, 8'h00);
    wr(7'h20, 8'hff);
    expect_reg(7'h20, 8'h00);
    expect_reg(7'h0e, 8'h00);
    $display("test reset and unmapped done");
    for (int i = 0; i < 8; i++) begin
      led = (i == 0) ? 8'h55 : (i == 1) ? 8'haa : rnd();
      rx8 = rnd();
      rx_status_i <= rx8[3:0];
      wr(7'h0e, led);
      expect_reg(7'h0e, led);
      check({4'h0, indicator_pins_o}, pins_exp(led, rx8[3:0]));
      rx_status_i <= ~rx8[3:0];
      cycles(3);
      check({4'h0, indicator_pins_o}, pins_exp(led, ~rx8[3:0]));
    end
    $display("test indicator pins done");
    for (int i = 0; i < 3; i++) begin
      chan_b_fault_i <= 3'b001 << i;
      cycles(12);
      check({7'h0, shared_status_irq_o}, 8'h01);
      expect_reg(7'h0d, (8'h01 << i) | (8'h08 << i));
      expect_reg(7'h0d, 8'h01 << i);
      check({7'h0, shared_status_irq_o}, 8'h00);
      chan_b_fault_i <= chan_status_pkg::FAULT_CLEAR;
      cycles(12);
      expect_reg(7'h0d, 8'h00);
    end
    $display("test fault flags done");
    wr(7'h0d, 8'h7f);
    expect_reg(7'h0d, 8'h40);
    check({7'h0, chan_b_internal_framer_on_o}, 8'h01);
    wr(7'h0e, 8'ha5);
    chan_b_fault_i <= 3'b100;
    cycles(12);
    soft_seen = 0;
    wr(7'h0d, 8'h80);
    check(8'(soft_seen), 8'h01);
    check({7'h0, chan_b_internal_framer_on_o}, 8'h00);
    check({7'h0, shared_status_irq_o}, 8'h00);
    expect_reg(7'h0d, 8'h04);
    expect_reg(7'h0e, 8'ha5);
    chan_b_fault_i <= chan_status_pkg::FAULT_CLEAR;
    $display("test soft reset done");
    conclude();
  end
endmodule : chan_status_led_ctrl_tb

`default_nettype wire
